// [rtl/pts_timer.sv]
// Period timer with prescaler, postscaler, AXI4-Lite registers and interrupt
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pts_cfg.svh"
module pts_timer #(
   parameter int BASE_DIV = `PTS_BASE_DIV
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Timer outputs
   output logic match_pulse,
   output logic irq
);
   import pts_pkg::*;

   typedef struct packed {
      pts_bus_e st;
      logic aw_ok;
      logic w_ok;
      logic [7:0] aidx;
      logic [7:0] wd;
      logic wlane;
      logic [1:0] bresp;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [7:0] count;
      logic [7:0] period;
      pts_ctrl_s ctrl;
      logic [7:0] flags;
      logic [7:0] enables;
      logic [7:0] mask;
      logic [1:0] base;
   } pts_state_s;

   pts_state_s s_q, s_d;
   pts_req_s req;
   logic base_tick, pre_tick, post_pulse, scaler_clr, inc;
   logic [3:0] pre_ratio;

   // Word index from a byte address; misaligned or high bits miss the map
   function automatic logic [8:0] dec_idx(input logic [31:0] a);
      dec_idx = (a[1:0] == 2'b00 && a[31:10] == '0) ? {1'b1, a[9:2]} : 9'h000;
   endfunction

   function automatic logic mapped(input logic [7:0] i);
      mapped = (i == `PTS_IDX_FLAGS) || (i == `PTS_IDX_COUNT) || (i == `PTS_IDX_CTRL)
         || (i == `PTS_IDX_ENABLES) || (i == `PTS_IDX_PERIOD) || (i == `PTS_IDX_MASK);
   endfunction

   // Instruction clock: one enable every BASE_DIV bus clocks
   assign base_tick = (s_q.base == 2'(BASE_DIV - 1));

   always_comb begin
      case (s_q.ctrl.clock_divider_select)
         2'b00: pre_ratio = 4'h0;
         2'b01: pre_ratio = 4'h3;
         default: pre_ratio = `PTS_PRE_MAX;
      endcase
   end

   pts_scaler #(.WIDTH(4)) u_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(scaler_clr),
      .tick(base_tick && s_q.ctrl.timer_run),
      .ratio_m1(pre_ratio),
      .pulse(pre_tick)
   );

   assign inc = pre_tick;
   assign match_pulse = inc && (s_q.count == s_q.period);

   pts_scaler #(.WIDTH(4)) u_post (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(scaler_clr),
      .tick(match_pulse),
      .ratio_m1(s_q.ctrl.match_divider_select),
      .pulse(post_pulse)
   );

   // Handshakes combinational from state
   assign awready = (s_q.st == PTS_IDLE) && !s_q.aw_ok;
   assign wready = (s_q.st == PTS_IDLE) && !s_q.w_ok;
   assign arready = (s_q.st == PTS_IDLE) && !s_q.aw_ok && !s_q.w_ok;
   assign bvalid = (s_q.st == PTS_WRESP);
   assign rvalid = (s_q.st == PTS_RRESP);
   assign bresp = s_q.bresp;
   assign rresp = s_q.rresp;
   assign rdata = s_q.rdata;
   assign irq = |(s_q.flags & s_q.enables & s_q.mask);

   always_comb begin
      logic [8:0] ai;
      logic aw_now, w_now;
      logic [7:0] widx, wbyte;
      logic wl;
      ai = '0;
      widx = s_q.aidx;
      wbyte = s_q.wd;
      wl = s_q.wlane;
      aw_now = awvalid && awready;
      w_now = wvalid && wready;
      req = '0;
      s_d = s_q;
      s_d.base = base_tick ? 2'b00 : 2'(s_q.base + 1'b1);
      if (aw_now) begin
         ai = dec_idx(awaddr);
         widx = ai[8] ? ai[7:0] : 8'hFF;
         s_d.aidx = widx;
         s_d.aw_ok = 1'b1;
      end
      if (w_now) begin
         wbyte = wdata[7:0];
         wl = wstrb[0];
         s_d.wd = wbyte;
         s_d.wlane = wl;
         s_d.w_ok = 1'b1;
      end
      case (s_q.st)
         PTS_IDLE: begin
            if ((s_q.aw_ok || aw_now) && (s_q.w_ok || w_now)) begin
               req.we = wl && mapped(widx);
               req.idx = widx;
               req.wdata = wbyte;
               s_d.bresp = mapped(widx) ? 2'b00 : 2'b10;
               s_d.aw_ok = 1'b0;
               s_d.w_ok = 1'b0;
               s_d.st = PTS_WRESP;
            end else if (arvalid && arready) begin
               ai = dec_idx(araddr);
               req.re = 1'b1;
               req.ridx = ai[8] ? ai[7:0] : 8'hFF;
               s_d.rresp = mapped(req.ridx) ? 2'b00 : 2'b10;
               s_d.st = PTS_RRESP;
            end
         end
         PTS_WRESP: begin
            if (bready) begin
               s_d.st = PTS_IDLE;
            end
         end
         PTS_RRESP: begin
            if (rready) begin
               s_d.st = PTS_IDLE;
            end
         end
         default: begin
            s_d.st = PTS_IDLE;
         end
      endcase
      if (req.re) begin
         case (req.ridx)
            `PTS_IDX_FLAGS: s_d.rdata = {24'h000000, s_q.flags};
            `PTS_IDX_COUNT: s_d.rdata = {24'h000000, s_q.count};
            `PTS_IDX_CTRL: s_d.rdata = {24'h000000, 1'b0, s_q.ctrl};
            `PTS_IDX_ENABLES: s_d.rdata = {24'h000000, s_q.enables};
            `PTS_IDX_PERIOD: s_d.rdata = {24'h000000, s_q.period};
            `PTS_IDX_MASK: s_d.rdata = {24'h000000, s_q.mask};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
      // Timer count; a count write overrides the increment in that cycle
      if (inc) begin
         s_d.count = match_pulse ? 8'h00 : 8'(s_q.count + 1'b1);
      end
      if (req.we) begin
         case (req.idx)
            `PTS_IDX_COUNT: s_d.count = req.wdata;
            `PTS_IDX_CTRL: s_d.ctrl = pts_ctrl_s'(req.wdata[6:0]);
            `PTS_IDX_PERIOD: s_d.period = req.wdata;
            `PTS_IDX_ENABLES: s_d.enables = req.wdata;
            `PTS_IDX_MASK: s_d.mask = req.wdata;
            `PTS_IDX_FLAGS: s_d.flags = s_q.flags & ~req.wdata;
            default: s_d.flags = s_d.flags;
         endcase
      end
      // Set beats the write-one clear in the same cycle
      if (post_pulse) begin
         s_d.flags[`PTS_FLAG_BIT] = 1'b1;
      end
   end

   // Prescaler and postscaler restart on count or control writes
   assign scaler_clr = req.we && (req.idx == `PTS_IDX_COUNT || req.idx == `PTS_IDX_CTRL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.st <= PTS_IDLE;
         s_q.count <= `PTS_RST_COUNT;
         s_q.period <= `PTS_RST_PERIOD;
         s_q.ctrl <= pts_ctrl_s'(7'h00);
         s_q.mask <= `PTS_RST_MASK;
      end else begin
         s_q <= s_d;
      end
   end

   // Checks
   sequence seq_match;
      match_pulse && s_q.ctrl.timer_run;
   endsequence

   AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
      (seq_match and !req.we) |=> s_q.count == 8'h00)
      else $error("Count did not wrap after match");
   AST_INC: assert property (@(posedge aclk) disable iff (!aresetn)
      inc && !match_pulse && !req.we |=> s_q.count == $past(s_q.count) + 8'h01)
      else $error("Count did not increment");
   AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
      !s_q.ctrl.timer_run && !req.we |=> $stable(s_q.count))
      else $error("Count moved while stopped");
   AST_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      post_pulse |=> s_q.flags[`PTS_FLAG_BIT])
      else $error("Postscaled match did not set flag");
   AST_CTRLW: assert property (@(posedge aclk) disable iff (!aresetn)
      req.we && req.idx == `PTS_IDX_CTRL && !inc |=> $stable(s_q.count))
      else $error("Control write changed count");
   AST_SCLR: assert property (@(posedge aclk) disable iff (!aresetn)
      scaler_clr |=> !pre_tick || pre_ratio == 4'h0)
      else $error("Prescaler not cleared by write");
   AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
      irq |-> (s_q.flags & s_q.enables) != 8'h00)
      else $error("Interrupt without enabled flag");
   AST_POST1: assert property (@(posedge aclk) disable iff (!aresetn)
      match_pulse && s_q.ctrl.match_divider_select == 4'h0 |-> post_pulse)
      else $error("Ratio 1:1 did not pass match");
   AST_PRE16: assert property (@(posedge aclk) disable iff (!aresetn)
      pre_tick && s_q.ctrl.clock_divider_select[1] |=> !pre_tick [*8])
      else $error("Prescaler 1:16 ticked early");
   AST_RST: assert property (@(posedge aclk)
      !aresetn |=> s_q.count == 8'h00 && s_q.period == 8'hFF && s_q.ctrl == 7'h00)
      else $error("Reset values wrong");

   // Bus answers must stand until taken
   sequence seq_b_wait;
      bvalid && !bready;
   endsequence

   sequence seq_r_wait;
      rvalid && !rready;
   endsequence

   AST_BHOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      seq_b_wait |=> bvalid && $stable(bresp))
      else $error("Write response dropped before taken");
   AST_RHOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      seq_r_wait |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("Read data dropped before taken");
   AST_CNTW: assert property (@(posedge aclk) disable iff (!aresetn)
      req.we && req.idx == `PTS_IDX_COUNT |=> s_q.count == $past(req.wdata))
      else $error("Count write not stored");
   AST_PERW: assert property (@(posedge aclk) disable iff (!aresetn)
      req.we && req.idx == `PTS_IDX_PERIOD |=> s_q.period == $past(req.wdata))
      else $error("Period write not stored");
   AST_TOP0: assert property (@(posedge aclk) disable iff (!aresetn)
      req.re && req.ridx == `PTS_IDX_CTRL |=> s_q.rdata[7] == 1'b0)
      else $error("Control top bit read as one");
   AST_W1C: assert property (@(posedge aclk) disable iff (!aresetn)
      req.we && req.idx == `PTS_IDX_FLAGS && req.wdata[`PTS_FLAG_BIT] && !post_pulse
      |=> !s_q.flags[`PTS_FLAG_BIT])
      else $error("Flag not cleared by writing one");
   AST_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
      s_q.flags[`PTS_FLAG_BIT] && !(req.we && req.idx == `PTS_IDX_FLAGS && req.wdata[1])
      |=> s_q.flags[`PTS_FLAG_BIT])
      else $error("Flag dropped without clear");
   AST_POSTCLR: assert property (@(posedge aclk) disable iff (!aresetn)
      scaler_clr |=> !post_pulse || s_q.ctrl.match_divider_select == 4'h0)
      else $error("Postscaler not cleared by write");
   AST_MONE: assert property (@(posedge aclk) disable iff (!aresetn)
      match_pulse |=> !match_pulse)
      else $error("Match pulse longer than one cycle");
endmodule

// [shared/pts_cfg.svh]
// Register offsets, field positions, reset values and timing for the period timer
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH
`define PTS_IDX_FLAGS 8'h0C
`define PTS_IDX_COUNT 8'h11
`define PTS_IDX_CTRL 8'h12
`define PTS_IDX_ENABLES 8'h8C
`define PTS_IDX_PERIOD 8'h92
`define PTS_IDX_MASK 8'hA0
`define PTS_RST_COUNT 8'h00
`define PTS_RST_PERIOD 8'hFF
`define PTS_RST_CTRL 8'h00
`define PTS_RST_MASK 8'hFF
`define PTS_CTRL_MASK 8'h7F
`define PTS_FLAG_BIT 1
`define PTS_RESERVED_BIT 6
`define PTS_RUN_BIT 2
`define PTS_CKPS_LSB 0
`define PTS_OUTPS_LSB 3
`define PTS_BASE_DIV 4
`define PTS_PRE_MAX 4'hF
`endif

// [shared/pts_pkg.sv]
// Types shared by the period timer
package pts_pkg;
   typedef struct packed {
      logic [3:0] match_divider_select;
      logic timer_run;
      logic [1:0] clock_divider_select;
   } pts_ctrl_s;
   typedef enum logic [2:0] {
      PTS_IDLE = 3'b001,
      PTS_WRESP = 3'b010,
      PTS_RRESP = 3'b100
   } pts_bus_e;
   typedef struct packed {
      logic we;
      logic [7:0] idx;
      logic [7:0] wdata;
      logic re;
      logic [7:0] ridx;
   } pts_req_s;
endpackage

// [rtl/pts_scaler.sv]
// Clock-enable divider used for the prescaler and postscaler
`timescale 1ns/1ps
module pts_scaler #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic clear,
   input wire logic tick,
   input wire logic [WIDTH-1:0] ratio_m1,
   // Output
   output logic pulse
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } pts_sc_s;
   pts_sc_s s_q, s_d;
   // Pulse kept apart so the clear input forms no false loop
   assign pulse = tick && (s_q.cnt >= ratio_m1);
   always_comb begin
      s_d = s_q;
      if (clear) begin
         s_d.cnt = '0;
      end else if (tick) begin
         s_d.cnt = pulse ? '0 : WIDTH'(s_q.cnt + 1'b1);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// [sim/pts_ssp_model.sv]
// Serial port stand-in that times the prescaled match pulses ahead of the postscaler
`timescale 1ns/1ps
module pts_ssp_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Shift clock source
   input wire logic match_pulse,
   // Pulse count and spacing seen
   output int n_pulses,
   output int gap
);
   int cyc;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cyc <= 0;
         n_pulses <= 0;
         gap <= 0;
      end else if (match_pulse) begin
         gap <= cyc + 1;
         cyc <= 0;
         n_pulses <= n_pulses + 1;
      end else begin
         cyc <= cyc + 1;
      end
   end
endmodule

// [sim/pts_timer_tb_top.sv]
// Self-checking bench for the period timer
`timescale 1ns/1ps
`include "pts_cfg.svh"
module pts_timer_tb_top;
   localparam int BD = 4;
   localparam logic [31:0] A_FLG = 32'(`PTS_IDX_FLAGS) * 4;
   localparam logic [31:0] A_CNT = 32'(`PTS_IDX_COUNT) * 4;
   localparam logic [31:0] A_CTL = 32'(`PTS_IDX_CTRL) * 4;
   localparam logic [31:0] A_ENA = 32'(`PTS_IDX_ENABLES) * 4;
   localparam logic [31:0] A_PER = 32'(`PTS_IDX_PERIOD) * 4;
   localparam logic [31:0] A_MSK = 32'(`PTS_IDX_MASK) * 4;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, match_pulse, irq;
   logic [31:0] awaddr, wdata, araddr, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   int bad_count, n_tests, cyc, n0, n_seen, gap;
   pts_timer #(.BASE_DIV(BD)) uut (.aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .match_pulse(match_pulse), .irq(irq));
   pts_ssp_model ssp (.aclk(aclk), .aresetn(aresetn), .match_pulse(match_pulse),
      .n_pulses(n_seen), .gap(gap));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Both write channels offered together, each dropped once taken
   task automatic wr(input logic [31:0] a, input logic [7:0] v, output logic [1:0] resp);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      resp = bresp;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      v = rdata;
      resp = rresp;
   endtask
   task automatic wrc(input logic [31:0] a, input logic [7:0] v);
      wr(a, v, r);
      chk("bresp", {30'h0, r}, 32'h0);
   endtask
   task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
      rd(a, d, r);
      chk(what, d, exp);
   endtask
   task automatic irq_is(input logic e);
      @(posedge aclk);
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask
   task automatic t_reset();
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rdc("count", A_CNT, 32'h0);
      rdc("period", A_PER, 32'hFF);
      rdc("control", A_CTL, 32'h0);
      rdc("flags", A_FLG, 32'h0);
      irq_is(1'b0);
      $display("reset test done");
   endtask
   task automatic t_regs();
      wrc(A_PER, 8'h5A);
      rdc("period rw", A_PER, 32'h5A);
      wstrb <= 4'hE;
      wrc(A_PER, 8'h11);
      wstrb <= 4'hF;
      rdc("period lane off", A_PER, 32'h5A);
      wrc(A_CTL, 8'hFB);
      rdc("control top bit", A_CTL, 32'h7B);
      wrc(A_CNT, 8'h33);
      rdc("count rw", A_CNT, 32'h33);
      wr(32'h4, 8'h01, r);
      chk("unmapped bresp", {30'h0, r}, 32'h2);
      rd(32'h4, d, r);
      chk("unmapped rresp", {30'h0, r}, 32'h2);
      chk("unmapped rdata", d, 32'h0);
      $display("register test done");
   endtask
   // Period 2 gives three increments between matches
   task automatic t_prescale();
      for (int k = 0; k < 4; k++) begin
         wrc(A_CTL, 8'h00);
         wrc(A_PER, 8'h02);
         wrc(A_CNT, 8'h00);
         wrc(A_CTL, 8'h04 | 8'(k));
         n0 = n_seen;
         while (n_seen < n0 + 2) @(posedge aclk);
         chk("match gap", 32'(gap), 32'(3 * BD * (k == 0 ? 1 : (k == 1 ? 4 : 16))));
      end
      $display("prescale test done");
   endtask
   task automatic t_post(input logic [3:0] n);
      wrc(A_CTL, 8'h00);
      wrc(A_PER, 8'h01);
      wrc(A_CNT, 8'h00);
      wrc(A_ENA, 8'h02);
      wrc(A_FLG, 8'h02);
      n0 = n_seen;
      wrc(A_CTL, {1'b0, n, 3'b100});
      while (!irq) @(posedge aclk);
      chk("matches per flag", 32'(n_seen - n0), 32'(n) + 1);
      wrc(A_CTL, 8'h00);
      rdc("sticky flag", A_FLG, 32'h2);
      wrc(A_ENA, 8'h00);
      irq_is(1'b0);
      wrc(A_ENA, 8'h02);
      irq_is(1'b1);
      wrc(A_MSK, 8'h00);
      irq_is(1'b0);
      wrc(A_MSK, 8'hFF);
      irq_is(1'b1);
      wrc(A_FLG, 8'h02);
      irq_is(1'b0);
      $display("postscale test done");
   endtask
   // Each 40-cycle wait is shorter than one 1:16 increment of 64 cycles; the two together span one unless the control write clears it
   task automatic t_clears();
      wrc(A_PER, 8'hFF);
      wrc(A_CTL, 8'h06);
      wrc(A_CNT, 8'h10);
      repeat (40) @(posedge aclk);
      wrc(A_CTL, 8'h06);
      repeat (40) @(posedge aclk);
      rdc("count kept", A_CNT, 32'h10);
      wrc(A_CTL, 8'h02);
      rd(A_CNT, d, r);
      repeat (100) @(posedge aclk);
      rdc("stopped count", A_CNT, d);
      $display("scaler clear test done");
   endtask
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 32'h0;
      wdata = 32'h0;
      araddr = 32'h0;
      wstrb = 4'hF;
      t_reset();
      t_regs();
      t_prescale();
      t_post(4'h0);
      t_post(4'h3);
      t_post(4'hF);
      t_clears();
      t_reset();
      give_verdict();
   end
endmodule
